/* hdl/wdt_pkg.sv */
package wdt_pkg;
    localparam logic [15:0] WDT_RESTART_ADDR = 16'hFF99;
    localparam logic [15:0] WDT_OPTION_ADDR = 16'h0080;
    localparam logic [15:0] WDT_EXEMPT_BASE = 16'hFB00;
    localparam logic [7:0] WDT_RESTART_KEY = 8'hAC;
    localparam logic [7:0] WDT_RESTART_RST_ON = 8'h9A;
    localparam logic [7:0] WDT_RESTART_RST_OFF = 8'h1A;
    localparam int WDT_OPT_WIN_HI = 6;
    localparam int WDT_OPT_WIN_LO = 5;
    localparam int WDT_OPT_EN = 4;
    localparam int WDT_OPT_OVF_HI = 3;
    localparam int WDT_OPT_OVF_LO = 1;
    localparam logic [1:0] WDT_WIN_FULL = 2'h3;
    localparam int WDT_CAUSE_BIT = 4;
    localparam int WDT_CNT_W = 17;
    localparam logic [16:0] WDT_CNT_ONES = 17'h1FFFF;
    localparam logic [4:0] WDT_OVF_EXP_BASE = 5'h0A;
    localparam logic [7:0] WDT_FLAGS_RST = 8'h00;
    typedef enum logic [1:0] {
        WDT_ST_CFG = 2'b00,
        WDT_ST_RUN = 2'b01,
        WDT_ST_IDLE = 2'b10,
        WDT_ST_FIRED = 2'b11
    } wdt_state_t;
endpackage : wdt_pkg

/* hdl/wdt_watchdog.sv */
`timescale 1ns/1ps
module wdt_watchdog
    import wdt_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // low-speed oscillator and option byte
    input wire logic lowspeed_clk,
    input wire logic [7:0] option_byte,
    // processor memory bus
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_bit_op,
    input wire logic mem_fetch,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    // memory size decode
    input wire logic [15:0] internal_mem_size,
    input wire logic [15:0] expanded_ram_size,
    // reset logic
    input wire logic reset_cause_flags_clear,
    output logic internal_reset,
    output logic [7:0] reset_cause_flags
);

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_ff;
    logic rst_n;
    wdt_state_t state_ff;
    logic [1:0] window_period_sel_ff;
    logic watchdog_count_enable_ff;
    logic [2:0] overflow_sel_ff;
    logic ls_prev_ff;
    logic [WDT_CNT_W-1:0] cnt_ff;
    logic first_write_ff;
    logic pend_ff;
    logic wdt_reset_ff;
    logic [7:0] rdata_ff;
    logic [7:0] flags_ff;

    logic ls_rise;
    logic restart_wr;
    logic restart_rd;
    logic restart_ok;
    logic restart_bad;
    logic in_area;
    logic fetch_bad;
    logic access_bad;
    logic running;
    logic ovf_hit;
    logic [4:0] ovf_exp;
    logic [WDT_CNT_W-1:0] cnt_max;
    logic [7:0] restart_rst_val;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // option byte capture and sequencing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= WDT_ST_CFG;
            window_period_sel_ff <= 2'h0;
            watchdog_count_enable_ff <= 1'b0;
            overflow_sel_ff <= 3'h0;
        end else begin
            case (state_ff)
                WDT_ST_CFG: begin
                    window_period_sel_ff <= option_byte[WDT_OPT_WIN_HI:WDT_OPT_WIN_LO];
                    watchdog_count_enable_ff <= option_byte[WDT_OPT_EN];
                    overflow_sel_ff <= option_byte[WDT_OPT_OVF_HI:WDT_OPT_OVF_LO];
                    state_ff <= option_byte[WDT_OPT_EN] ? WDT_ST_RUN : WDT_ST_IDLE;
                end
                WDT_ST_RUN: begin
                    if (ovf_hit || (pend_ff && ls_rise)) begin
                        state_ff <= WDT_ST_FIRED;
                    end
                end
                WDT_ST_IDLE: state_ff <= WDT_ST_IDLE;
                WDT_ST_FIRED: state_ff <= WDT_ST_FIRED;
                default: state_ff <= WDT_ST_CFG;
            endcase
        end
    end

    assign running = (state_ff == WDT_ST_RUN);
    assign restart_rst_val = watchdog_count_enable_ff ? WDT_RESTART_RST_ON : WDT_RESTART_RST_OFF;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode and violation detection
    assign restart_wr = mem_wr && (mem_addr == WDT_RESTART_ADDR);
    assign restart_rd = mem_rd && (mem_addr == WDT_RESTART_ADDR);
    assign restart_ok = restart_wr && !mem_bit_op && (mem_wdata == WDT_RESTART_KEY)
        && ((window_period_sel_ff == WDT_WIN_FULL) || first_write_ff);
    assign restart_bad = restart_wr && !restart_ok;
    assign in_area = (mem_addr < internal_mem_size) || (mem_addr >= expanded_ram_size);
    assign fetch_bad = mem_fetch && !in_area;
    assign access_bad = (mem_rd || mem_wr) && !mem_fetch && !in_area && (mem_addr < WDT_EXEMPT_BASE);

    ////////////////////////////////////////////////////////////////////////////
    // low-speed counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ls_prev_ff <= 1'b0;
        end else begin
            ls_prev_ff <= lowspeed_clk;
        end
    end
    assign ls_rise = lowspeed_clk && !ls_prev_ff;

    assign ovf_exp = WDT_OVF_EXP_BASE + {2'h0, overflow_sel_ff};
    assign cnt_max = ~(WDT_CNT_ONES << ovf_exp);
    assign ovf_hit = running && ls_rise && (cnt_ff == cnt_max) && !restart_ok;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (!running) begin
            cnt_ff <= cnt_ff;
        end else if (restart_ok) begin
            cnt_ff <= '0;
        end else if (ls_rise) begin
            cnt_ff <= cnt_ff + {{(WDT_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_write_ff <= 1'b1;
        end else if (running && restart_wr) begin
            first_write_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset generation, waits for a low-speed edge when held off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
        end else if (running && (restart_bad || fetch_bad || access_bad)) begin
            pend_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_reset_ff <= 1'b0;
        end else if (ovf_hit || (running && pend_ff && ls_rise)) begin
            wdt_reset_ff <= 1'b1;
        end
    end
    assign internal_reset = wdt_reset_ff;

    // cause flag survives the internal reset; set beats clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= WDT_FLAGS_RST;
        end else if (ovf_hit || (running && pend_ff && ls_rise)) begin
            flags_ff[WDT_CAUSE_BIT] <= 1'b1;
        end else if (reset_cause_flags_clear) begin
            flags_ff <= WDT_FLAGS_RST;
        end
    end
    assign reset_cause_flags = flags_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (restart_rd) begin
            rdata_ff <= restart_rst_val;
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign mem_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_fault;
        running && (restart_bad || fetch_bad || access_bad);
    endsequence
    sequence seq_fire_later;
        pend_ff ##[0:1000] (wdt_reset_ff || !running);
    endsequence

    AST_OVERFLOW: assert property (ovf_hit |=> wdt_reset_ff && state_ff == WDT_ST_FIRED)
        else $error("overflow did not raise internal reset");
    AST_BITOP: assert property (running && restart_wr && mem_bit_op |=> pend_ff)
        else $error("bit op on restart register not flagged");
    AST_BADKEY: assert property (running && restart_wr && mem_wdata != WDT_RESTART_KEY |=> pend_ff)
        else $error("wrong restart value not flagged");
    AST_WINDOW: assert property (running && restart_wr && !first_write_ff
        && window_period_sel_ff != WDT_WIN_FULL |=> pend_ff)
        else $error("write in closed window not flagged");
    AST_FAULT_SEQ: assert property (seq_fault |=> seq_fire_later)
        else $error("fault did not lead to internal reset");
    AST_EXEMPT: assert property (running && !pend_ff && !mem_fetch && !restart_wr
        && mem_addr >= WDT_EXEMPT_BASE |=> !pend_ff)
        else $error("exempt area access flagged");
    AST_CAUSE: assert property ($rose(wdt_reset_ff) |-> flags_ff[WDT_CAUSE_BIT])
        else $error("reset cause flag not set");
    AST_RESTART: assert property (restart_ok && running |=> cnt_ff == '0 && !wdt_reset_ff)
        else $error("good restart did not clear counter");
    AST_READ: assert property (restart_rd |=> mem_rdata == $past(restart_rst_val)
        && mem_rdata != WDT_RESTART_KEY)
        else $error("restart register read value wrong");
    AST_WAIT_EDGE: assert property (!wdt_reset_ff && !ovf_hit && !ls_rise |=> !wdt_reset_ff)
        else $error("reset fired without low-speed edge");
    AST_DISABLED: assert property (state_ff == WDT_ST_IDLE |-> cnt_ff == '0 && !wdt_reset_ff && !pend_ff)
        else $error("disabled watchdog is active");
    AST_CFG_HOLD: assert property (state_ff != WDT_ST_CFG |=> $stable(overflow_sel_ff)
        && $stable(watchdog_count_enable_ff) && $stable(window_period_sel_ff))
        else $error("configuration changed after capture");

endmodule : wdt_watchdog

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    import wdt_pkg::*;
    logic core_clk, arst_n, ls_run, lowspeed_clk, mem_rd, mem_wr, mem_bit_op, mem_fetch, reset_cause_flags_clear, internal_reset;
    logic [7:0] option_byte, mem_wdata, mem_rdata, reset_cause_flags;
    logic [15:0] mem_addr;
    logic [31:0] lfsr_ff;
    int errors, compares;
    wdt_lsosc u_wdt_lsosc (.core_clk, .run(ls_run), .lowspeed_clk);
    wdt_watchdog u_wdt_watchdog (.core_clk, .arst_n, .lowspeed_clk, .option_byte, .mem_addr, .mem_rd, .mem_wr,
        .mem_bit_op, .mem_fetch, .mem_wdata, .mem_rdata, .internal_mem_size(16'h8000),
        .expanded_ram_size(16'hFF00), .reset_cause_flags_clear, .internal_reset, .reset_cause_flags);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] rst_val(input logic en);
        return en ? 8'h9A : 8'h1A;
    endfunction : rst_val
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        if (errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic restart(input logic [7:0] opt);
        arst_n <= 1'b0;
        option_byte <= opt;
        cyc(3);
        arst_n <= 1'b1;
        cyc(4);
    endtask : restart
    // one byte-wide access only
    task automatic bus(input logic [15:0] a, input logic rd, wr, bop, fe, input logic [7:0] d);
        @(posedge core_clk);
        {mem_addr, mem_rd, mem_wr, mem_bit_op, mem_fetch, mem_wdata} <= {a, rd, wr, bop, fe, d};
        @(posedge core_clk);
        {mem_rd, mem_wr, mem_bit_op, mem_fetch} <= 4'h0;
    endtask : bus
    // look off the edge, then hand back on an edge
    task automatic fault_chk(input logic exp);
        cyc(12);
        #1;
        chk("internal_reset", {7'h00, internal_reset}, {7'h00, exp});
        chk("cause flag", {7'h00, reset_cause_flags[WDT_CAUSE_BIT]}, {7'h00, exp});
        cyc(1);
    endtask : fault_chk
    ////////////////////////////////////////////////////////////////
    initial begin
        {arst_n, mem_rd, mem_wr, mem_bit_op, mem_fetch, reset_cause_flags_clear} = 6'h00;
        {option_byte, mem_wdata, mem_addr} = 32'h0070_0000;
        ls_run = 1'b1;
        lfsr_ff = 32'hD16B;
        errors = 0;
        compares = 0;
        for (int e = 0; e < 2; e++) begin
            restart({3'b011, e[0], 4'h0});
            bus(WDT_RESTART_ADDR, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
            #1 chk("restart read", mem_rdata, rst_val(e[0]));
            bus(WDT_RESTART_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, WDT_RESTART_KEY);
            bus(WDT_RESTART_ADDR, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
            #1 chk("read after key", mem_rdata, rst_val(e[0]));
            bus(16'h9000, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
            fault_chk(e[0]);
        end
        restart(8'h70);
        repeat (20) begin
            lfsr_ff = lfsr_next(lfsr_ff);
            bus({1'b0, lfsr_ff[14:0]}, lfsr_ff[16], 1'b0, 1'b0, ~lfsr_ff[16], 8'h00);
            bus(16'hFB00 + {6'h00, lfsr_ff[25:16]}, lfsr_ff[26], ~lfsr_ff[26], 1'b0, 1'b0, lfsr_ff[7:0]);
            bus(WDT_RESTART_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, WDT_RESTART_KEY);
        end
        fault_chk(1'b0);
        do lfsr_ff = lfsr_next(lfsr_ff); while (lfsr_ff[7:0] == WDT_RESTART_KEY);
        bus(WDT_RESTART_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, lfsr_ff[7:0]);
        fault_chk(1'b1);
        reset_cause_flags_clear <= 1'b1;
        cyc(1);
        reset_cause_flags_clear <= 1'b0;
        cyc(1);
        #1 chk("cleared flags", reset_cause_flags, 8'h00);
        // bit op on restart, read at B800H, write at EF00H
        for (int k = 0; k < 3; k++) begin
            restart(8'h70);
            bus(k == 0 ? WDT_RESTART_ADDR : 16'h8100 + 16'(k * 16'h3700), k == 1, k != 1, k == 0, 1'b0, 8'hAC);
            fault_chk(1'b1);
        end
        restart(8'h10);
        bus(WDT_RESTART_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, WDT_RESTART_KEY);
        fault_chk(1'b0);
        bus(WDT_RESTART_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, WDT_RESTART_KEY);
        fault_chk(1'b1);
        restart(8'h70);
        ls_run <= 1'b0;
        bus(WDT_RESTART_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, 8'h55);
        cyc(40);
        fault_chk(1'b0);
        ls_run <= 1'b1;
        fault_chk(1'b1);
        // late restart, so a missed clear would overflow early
        for (int s = 0; s < 2; s++) begin
            restart({5'b01110, s[1:0], 1'b0});
            cyc(2000);
            bus(WDT_RESTART_ADDR, 1'b0, 1'b1, 1'b0, 1'b0, WDT_RESTART_KEY);
            cyc((1 << (10 + s)) * 4 - 100);
            fault_chk(1'b0);
            cyc(150);
            fault_chk(1'b1);
        end
        conclude();
    end
    initial begin
        cyc(40000);
        errors++;
        conclude();
    end
endmodule : tb

/* testbench/wdt_lsosc.sv */
`timescale 1ns/1ps
module wdt_lsosc (
    // system side
    input wire logic core_clk,
    input wire logic run,
    // oscillator output
    output logic lowspeed_clk
);
    logic phase_ff;
    initial begin
        phase_ff = 1'b0;
        lowspeed_clk = 1'b0;
    end
    // stopped oscillator rests low
    always @(posedge core_clk) begin
        if (!run) begin
            lowspeed_clk <= 1'b0;
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= ~phase_ff;
            if (phase_ff) lowspeed_clk <= ~lowspeed_clk;
        end
    end
endmodule : wdt_lsosc
